/* design/link_regs.svh */
// Constants for the seven-slot four-lane word link: widths, slot timing and delay counts.
// Assumes a 250 MHz core clock and a link shift clock at seven times the word rate.
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

`define WORD_BITS          28
`define LANES              4
`define SLOTS              7
`define SLOT_LAST          3'h6
`define FWD_HIGH_SLOTS     3'h4
`define FIFO_WORDS         8
`define CLK_MHZ            250
`define GAP_LIMIT          5'he
`define LOCK_WORDS_LAST    2'h3
`define LOCK_CNT_W         22
`define RX_LOCK_TIME_MS    10
`define RX_LOCK_CYC        (`RX_LOCK_TIME_MS * 1000 * `CLK_MHZ)
`define RX_SLEEP_ENTRY_US  1
`define RX_SLEEP_ENTRY_CYC (`RX_SLEEP_ENTRY_US * `CLK_MHZ)

`endif

/* design/link_pkg.sv */
// Types shared by the word link: lock states and the per-domain state records.
// Assumes the constants header is on the include path.
`include "link_regs.svh"

package link_pkg;

	typedef enum logic [2:0]
	{
		RX_HUNT  = 3'b001,
		RX_TRACK = 3'b010,
		RX_LOCK  = 3'b100
	} rx_lock_e;

	typedef struct packed
	{
		logic                    rst1;
		logic                    rst2;
		logic                    tslp1;
		logic                    tslp2;
		logic                    rslp1;
		logic                    rslp2;
		logic                    req1;
		logic                    req2;
		logic                    ack;
		logic [2:0]              tslot;
		logic [`WORD_BITS-1:0]   tword;
		logic [`LANES-1:0]       lane;
		logic                    fclk;
		logic                    oe;
		logic [`LANES-1:0]       ln1;
		logic [`LANES-1:0]       ln2;
		logic                    fc1;
		logic                    fc2;
		logic                    fc3;
		logic [2:0]              rslot;
		logic [4:0]              gap;
		logic                    absent;
		rx_lock_e                lk;
		logic [1:0]              good;
		logic [`WORD_BITS-1:0]   rword;
		logic [`WORD_BITS-1:0]   rhold;
		logic                    wtog;
		logic                    phase;
	} link_s;

	typedef struct packed
	{
		logic                    rslp1;
		logic                    rslp2;
		logic                    ack1;
		logic                    ack2;
		logic                    req;
		logic [`WORD_BITS-1:0]   hold;
		logic                    wt1;
		logic                    wt2;
		logic                    wt3;
		logic                    ph1;
		logic                    ph2;
		logic                    ph3;
		logic                    lk1;
		logic                    lk2;
		logic                    ab1;
		logic                    ab2;
		logic [`WORD_BITS-1:0]   pnd;
		logic                    pnd_v;
		logic [`WORD_BITS-1:0]   out_word;
		logic                    out_clk;
		logic                    locked;
		logic [`LOCK_CNT_W-1:0]  wait_cnt;
	} core_s;

endpackage

/* design/word_fifo.sv */
// Single-clock word FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; ready is registered and exact.
`timescale 1ns/1ps

module word_fifo
#(
	parameter int WIDTH = 28,
	parameter int DEPTH = 8
)
(
	input  wire logic             i_clk,   // Core clock.
	input  wire logic             i_nrst,  // Synchronous reset, active low.
	input  wire logic             i_valid, // Write side offers a word.
	output logic                  o_ready, // Write side may push.
	input  wire logic [WIDTH-1:0] i_data,  // Word pushed.
	output logic                  o_valid, // Read side has a word.
	input  wire logic             i_ready, // Read side takes the word.
	output logic [WIDTH-1:0]      o_data   // Oldest word.
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
		logic                        ready;
	} fifo_s;

	fifo_s r;
	fifo_s n;
	logic  push;
	logic  pop;

	always_comb
	begin
		n = r;
		push = i_valid && r.ready;
		pop = (r.count != '0) && i_ready;
		if (push)
		begin
			n.mem[r.wptr] = i_data;
			n.wptr = AW'(r.wptr + 1'b1);
		end
		if (pop)
		begin
			n.rptr = AW'(r.rptr + 1'b1);
		end
		case ({push, pop})
			2'b10:   n.count = (AW+1)'(r.count + 1'b1);
			2'b01:   n.count = (AW+1)'(r.count - 1'b1);
			default: n.count = r.count;
		endcase
		n.ready = (n.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			r <= '0;
			r.ready <= 1'b1;
		end
		else
		begin
			r <= n;
		end
	end

	assign o_ready = r.ready;
	assign o_valid = (r.count != '0);
	assign o_data = r.mem[r.rptr];

endmodule

/* design/seven_to_one_lvds_word_link.sv */
// Word link top: a source FIFO, a seven-slot four-lane serializer with forwarded clock,
// and the matching deserializer with lock detection and a recovered word clock.
// Assumes i_link_clk runs at seven times the word rate and the lane and clock inputs
// come from an outside wire; every such input is synchronised before use.
`timescale 1ns/1ps
`include "link_regs.svh"

module seven_to_one_lvds_word_link
	import link_pkg::*;
#(
	parameter int FIFO_DEPTH   = `FIFO_WORDS,
	parameter int LOCK_TIMEOUT = `RX_LOCK_CYC
)
(
	input  wire logic                  i_clk,                      // Core clock, 250 MHz.
	input  wire logic                  i_nrst,                     // Synchronous reset, low.
	input  wire logic                  i_link_clk,                 // Slot clock, 7 per word.
	input  wire logic [`WORD_BITS-1:0] i_parallel_source_word,     // Word to send.
	input  wire logic                  i_source_valid,             // Source word offered.
	output logic                       o_source_ready,             // FIFO accepts a word.
	input  wire logic                  i_tx_sleep_request_n,       // Transmit sleep, low.
	output logic [`LANES-1:0]          o_serial_lane_out,          // Serial lane levels.
	output logic [`LANES-1:0]          o_serial_lane_oe,           // Lane drive enables.
	output logic                       o_forwarded_link_clock_out, // Forwarded word clock.
	output logic                       o_forwarded_link_clock_oe,  // Its drive enable.
	input  wire logic [`LANES-1:0]     i_serial_lane_in,           // Received lane levels.
	input  wire logic                  i_forwarded_link_clock_in,  // Received word clock.
	input  wire logic                  i_rx_sleep_request_n,       // Receive sleep, low.
	output logic [`WORD_BITS-1:0]      o_parallel_sink_word,       // Received word.
	output logic                       o_recovered_word_clock,     // Strobe, rising edge.
	output logic                       o_rx_locked                 // Receiver locked.
);

	// ==========================================================
	// Source FIFO
	link_s                  l_r;
	link_s                  l_n;
	core_s                  c_r;
	core_s                  c_n;
	logic                   f_valid;
	logic                   f_ready;
	logic [`WORD_BITS-1:0]  f_data;
	logic                   t_clk_edge;
	logic                   r_clk_edge;
	logic                   good_s;
	logic [2:0]             r_slot;
	logic [`WORD_BITS-1:0]  t_word;

	word_fifo
	#(
		.WIDTH (`WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	)
	u_fifo
	(
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_valid (i_source_valid),
		.o_ready (o_source_ready),
		.i_data  (i_parallel_source_word),
		.o_valid (f_valid),
		.i_ready (f_ready),
		.o_data  (f_data)
	);

	// ==========================================================
	// Link domain: serializer, deserializer and lock tracking
	always_comb
	begin
		l_n = l_r;
		l_n.rst1 = i_nrst;
		l_n.rst2 = l_r.rst1;
		l_n.tslp1 = i_tx_sleep_request_n;
		l_n.tslp2 = l_r.tslp1;
		l_n.rslp1 = i_rx_sleep_request_n;
		l_n.rslp2 = l_r.rslp1;
		l_n.req1 = c_r.req;
		l_n.req2 = l_r.req1;
		l_n.ln1 = i_serial_lane_in;
		l_n.ln2 = l_r.ln1;
		l_n.fc1 = i_forwarded_link_clock_in;
		l_n.fc2 = l_r.fc1;
		l_n.fc3 = l_r.fc2;

		// Slot 0 is the rising edge of the forwarded clock; the held word is taken then
		// and shifted out over the next word period. Idle periods send zeros.
		t_clk_edge = (l_r.tslot == 3'h0);
		l_n.tslot = (l_r.tslot == `SLOT_LAST) ? 3'h0 : 3'(l_r.tslot + 3'h1);
		t_word = l_r.tword;
		if (t_clk_edge)
		begin
			t_word = (l_r.req2 != l_r.ack) ? c_r.hold : '0;
			l_n.ack = l_r.req2;
			l_n.tword = t_word;
		end
		for (int l = 0; l < `LANES; l++)
		begin
			l_n.lane[l] = t_word[l * `SLOTS + int'(l_r.tslot)];
		end
		l_n.fclk = (l_r.tslot < `FWD_HIGH_SLOTS);
		l_n.oe = l_r.tslp2;

		// Lane and clock inputs share one synchroniser depth, so slot 0 sits on ln2
		// in the same cycle that the clock edge shows on fc2.
		r_clk_edge = l_r.fc2 && !l_r.fc3;
		good_s = r_clk_edge && (l_r.gap == 5'h6);
		if (r_clk_edge)
		begin
			r_slot = 3'h0;
		end
		else
		begin
			r_slot = (l_r.rslot == `SLOT_LAST) ? `SLOT_LAST : 3'(l_r.rslot + 3'h1);
		end
		l_n.rslot = r_slot;
		if (r_clk_edge)
		begin
			l_n.gap = 5'h0;
		end
		else
		begin
			l_n.gap = (l_r.gap == `GAP_LIMIT) ? l_r.gap : 5'(l_r.gap + 5'h1);
		end
		l_n.absent = (l_n.gap == `GAP_LIMIT);
		for (int l = 0; l < `LANES; l++)
		begin
			l_n.rword[l * `SLOTS + int'(r_slot)] = l_r.ln2[l];
		end
		l_n.phase = (r_slot < `FWD_HIGH_SLOTS);
		if (r_slot == `SLOT_LAST && l_r.rslot == 3'h5 && l_r.lk == RX_LOCK)
		begin
			l_n.rhold = l_n.rword;
			l_n.wtog = !l_r.wtog;
		end

		case (l_r.lk)
			RX_HUNT:
			begin
				if (r_clk_edge)
				begin
					l_n.lk = RX_TRACK;
					l_n.good = 2'h0;
				end
			end
			RX_TRACK:
			begin
				if (r_clk_edge && !good_s)
				begin
					l_n.lk = RX_HUNT;
				end
				else if (good_s && l_r.good == `LOCK_WORDS_LAST)
				begin
					l_n.lk = RX_LOCK;
				end
				else if (good_s)
				begin
					l_n.good = 2'(l_r.good + 2'h1);
				end
			end
			RX_LOCK:
			begin
				if (r_clk_edge && !good_s)
				begin
					l_n.lk = RX_HUNT;
				end
			end
			default:
			begin
				l_n.lk = RX_HUNT;
			end
		endcase
		if (!l_r.rslp2 || l_r.absent)
		begin
			l_n.lk = RX_HUNT;
		end

		if (!l_r.rst2)
		begin
			l_n = '0;
			l_n.lk = RX_HUNT;
			l_n.rst1 = i_nrst;
			l_n.rst2 = l_r.rst1;
		end
	end

	always_ff @(posedge i_link_clk)
	begin
		l_r <= l_n;
	end

	// ==========================================================
	// Core domain: transmit handshake and receive presentation
	always_comb
	begin
		c_n = c_r;
		c_n.rslp1 = i_rx_sleep_request_n;
		c_n.rslp2 = c_r.rslp1;
		c_n.ack1 = l_r.ack;
		c_n.ack2 = c_r.ack1;
		c_n.wt1 = l_r.wtog;
		c_n.wt2 = c_r.wt1;
		c_n.wt3 = c_r.wt2;
		c_n.ph1 = l_r.phase;
		c_n.ph2 = c_r.ph1;
		c_n.ph3 = c_r.ph2;
		c_n.lk1 = (l_r.lk == RX_LOCK);
		c_n.lk2 = c_r.lk1;
		c_n.ab1 = l_r.absent;
		c_n.ab2 = c_r.ab1;

		// One word in flight: hold stays put until the link side has acknowledged it.
		f_ready = (c_r.req == c_r.ack2);
		if (f_valid && f_ready)
		begin
			c_n.hold = f_data;
			c_n.req = !c_r.req;
		end

		// Words change on the falling recovered edge so they stand still at the rising one.
		if (c_r.ph3 && !c_r.ph2 && c_r.pnd_v && !c_r.ab2)
		begin
			c_n.out_word = c_r.pnd;
			c_n.pnd_v = 1'b0;
		end
		if (c_r.wt2 != c_r.wt3)
		begin
			c_n.pnd = l_r.rhold;
			c_n.pnd_v = 1'b1;
		end
		c_n.out_clk = c_r.ab2 ? 1'b1 : c_r.ph2;
		c_n.locked = c_r.lk2 && c_r.rslp2;
		if (c_r.lk2 || c_r.ab2 || !c_r.rslp2)
		begin
			c_n.wait_cnt = '0;
		end
		else if (c_r.wait_cnt != '1)
		begin
			c_n.wait_cnt = `LOCK_CNT_W'(c_r.wait_cnt + 1'b1);
		end
		if (!c_r.rslp2)
		begin
			c_n.out_word = '0;
			c_n.out_clk = 1'b0;
			c_n.pnd_v = 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			c_r <= '0;
		end
		else
		begin
			c_r <= c_n;
		end
	end

	assign o_serial_lane_out = l_r.lane;
	assign o_serial_lane_oe = {`LANES{l_r.oe}};
	assign o_forwarded_link_clock_out = l_r.fclk;
	assign o_forwarded_link_clock_oe = l_r.oe;
	assign o_parallel_sink_word = c_r.out_word;
	assign o_recovered_word_clock = c_r.out_clk;
	assign o_rx_locked = c_r.locked;

	// ==========================================================
	// Checks
	localparam int SLEEP_MAX = `RX_SLEEP_ENTRY_CYC;

	sequence fwd_high_s;
		o_forwarded_link_clock_out [*4];
	endsequence

	sequence fwd_low_s;
		!o_forwarded_link_clock_out [*3];
	endsequence

	fwd_shape_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		$rose(o_forwarded_link_clock_out) |-> fwd_high_s ##1 fwd_low_s ##1
			o_forwarded_link_clock_out)
		else $error("Forwarded clock lost its four-high three-low shape.");

	slot_wrap_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		l_r.tslot == 3'h6 |=> l_r.tslot == 3'h0 ##6 l_r.tslot == 3'h6)
		else $error("Transmit slot count does not cycle through seven slots.");

	word_take_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		(l_r.tslot == 3'h0 && l_r.req2 != l_r.ack) |=>
			(l_r.tword == $past(c_r.hold) && l_r.ack == $past(l_r.req2)))
		else $error("Held word not taken at the forwarded clock edge.");

	lane_map_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		l_r.tslot == 3'h3 |=> o_serial_lane_out[2] == l_r.tword[17])
		else $error("Lane two slot three carries the wrong word bit.");

	tx_hiz_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		!l_r.tslp2 |=> (o_serial_lane_oe == 4'h0 && !o_forwarded_link_clock_oe))
		else $error("Serial outputs driven while asleep.");

	lock_step_a: assert property (
		@(posedge i_link_clk) disable iff (!l_r.rst2)
		(l_r.lk == RX_TRACK && good_s && l_r.good == 2'h3 && l_r.rslp2) |=>
			l_r.lk == RX_LOCK)
		else $error("Four good word periods did not give lock.");

	lock_time_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		int'(c_r.wait_cnt) < LOCK_TIMEOUT)
		else $error("Receiver failed to lock in time.");

	sleep_entry_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		$fell(i_rx_sleep_request_n) |-> ##[1:SLEEP_MAX]
			(o_parallel_sink_word == '0 && !o_recovered_word_clock))
		else $error("Receiver did not enter sleep in time.");

	sleep_low_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!c_r.rslp2 |=> (o_parallel_sink_word == '0 && !o_rx_locked))
		else $error("Receive outputs not low during sleep.");

	absent_hold_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(c_r.ab2 && c_r.rslp2) |=>
			(o_recovered_word_clock && $stable(o_parallel_sink_word)))
		else $error("Clock loss did not hold data with clock high.");

	rec_clk_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(c_r.rslp2 && !c_r.ab2 && !$past(c_r.ab2) && c_r.ph2 && !c_r.ph3) |=>
			$rose(o_recovered_word_clock))
		else $error("Recovered clock does not follow the link clock.");

	data_fall_a: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(c_r.rslp2 && $past(c_r.rslp2) && $changed(o_parallel_sink_word)) |->
			$fell(o_recovered_word_clock))
		else $error("Received word changed away from the falling strobe.");

endmodule

/* tb/link_cable.sv */
// Cable model standing between the link's serial outputs and its serial inputs.
// Assumes the link drives lanes and clock with enables; an undriven line reads high.
`timescale 1ns/1ps
`include "link_regs.svh"

module link_cable
(
	input  wire logic [`LANES-1:0] i_lane,      // Driven lane levels.
	input  wire logic [`LANES-1:0] i_lane_oe,   // Lane drive enables.
	input  wire logic              i_fclk,      // Driven clock level.
	input  wire logic              i_fclk_oe,   // Clock drive enable.
	input  wire logic              i_cut_lanes, // Lanes opened.
	output logic [`LANES-1:0]      o_lane,      // Lane level at receiver.
	output logic                   o_fclk       // Clock level at receiver.
);
	// An open or released line is held high by the failsafe bias.
	assign o_lane = i_cut_lanes ? {`LANES{1'b1}} : (i_lane | ~i_lane_oe);
	assign o_fclk = i_fclk_oe ? i_fclk : 1'b1;
endmodule

/* tb/seven_to_one_lvds_word_link_tb.sv */
// Self-checking bench for the word link, looped back through the cable model.
// Assumes a 4 ns core clock and a 30 ns link slot clock of unrelated phase.
`timescale 1ns/1ps
`include "link_regs.svh"

module seven_to_one_lvds_word_link_tb;
	import link_pkg::*;
	localparam int LOCK_T = 2000;
	logic                  clk, link_clk, nrst, valid, tx_n, rx_n, cut;
	logic [`WORD_BITS-1:0] word;
	logic                  ready, fclk, fclk_oe, fclk_in, strobe, locked;
	logic [`LANES-1:0]     lane, lane_oe, lane_in;
	logic [`WORD_BITS-1:0] sink;
	int                    bad_count, checks_done, cyc;

	seven_to_one_lvds_word_link #(.FIFO_DEPTH(`FIFO_WORDS), .LOCK_TIMEOUT(LOCK_T)) dut
	(
		.i_clk(clk), .i_nrst(nrst), .i_link_clk(link_clk),
		.i_parallel_source_word(word), .i_source_valid(valid), .o_source_ready(ready),
		.i_tx_sleep_request_n(tx_n), .o_serial_lane_out(lane), .o_serial_lane_oe(lane_oe),
		.o_forwarded_link_clock_out(fclk), .o_forwarded_link_clock_oe(fclk_oe),
		.i_serial_lane_in(lane_in), .i_forwarded_link_clock_in(fclk_in),
		.i_rx_sleep_request_n(rx_n), .o_parallel_sink_word(sink),
		.o_recovered_word_clock(strobe), .o_rx_locked(locked)
	);
	link_cable cable
	(
		.i_lane(lane), .i_lane_oe(lane_oe), .i_fclk(fclk), .i_fclk_oe(fclk_oe),
		.i_cut_lanes(cut), .o_lane(lane_in), .o_fclk(fclk_in)
	);

	// ==========================================================
	// Clocks, start values and timeout
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#7.3;
		forever #15 link_clk = ~link_clk;
	end
	initial
	begin
		{nrst, valid, cut} = 3'h0;
		{tx_n, rx_n} = 2'h3;
		word = 28'h0;
		{bad_count, checks_done, cyc} = 0;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			bad_count++;
			conclude();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Sink logic takes the word at a rising recovered strobe.
	task automatic wait_word(input logic [`WORD_BITS-1:0] w, output logic hit);
		logic prev;
		prev = 1'b1;
		hit = 1'b0;
		for (int i = 0; i < 1500 && !hit; i++)
		begin
			@(posedge clk);
			#1;
			if (strobe === 1'b1 && !prev && sink === w)
				hit = 1'b1;
			prev = strobe;
		end
	endtask

	task automatic wait_lock();
		int n;
		n = 0;
		while (locked !== 1'b1 && n < LOCK_T)
		begin
			@(posedge clk);
			n++;
		end
		check("lock", locked, 1'b1);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		repeat (40) @(posedge clk) nrst <= 1'b0;
		#1;
		check("reset sink", sink, 28'h0);
		check("reset lock", locked, 1'b0);
		check("reset ready", ready, 1'b1);
		@(posedge clk) nrst <= 1'b1;
		wait_lock();
	endtask

	task automatic t_period();
		int n;
		logic h;
		wait_word(28'h0, h);
		check("idle word", h, 1'b1);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (!(strobe === 1'b0) && n < 100);
		while (strobe !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("strobe period", (n >= 52 && n <= 53), 1'b1);
	endtask

	task automatic t_word(input logic [`WORD_BITS-1:0] w);
		logic [`WORD_BITS-1:0] got;
		logic                  prev, h;
		@(posedge clk) valid <= 1'b1;
		word <= w;
		@(posedge clk) valid <= 1'b0;
		got = 28'h0;
		prev = 1'b1;
		for (int p = 0; p < 600 && got !== w; p++)
		begin
			@(posedge link_clk);
			#1;
			if (fclk === 1'b1 && !prev)
				for (int s = 0; s < `SLOTS; s++)
				begin
					if (s > 0)
					begin
						@(posedge link_clk);
						#1;
					end
					for (int l = 0; l < `LANES; l++)
						got[l * `SLOTS + s] = lane[l];
				end
			prev = fclk;
		end
		check("lane word", got, w);
		wait_word(w, h);
		check("sink word", h, 1'b1);
	endtask

	task automatic t_fill();
		int   acc;
		logic r, low;
		acc = 0;
		low = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			@(negedge clk) r = ready;
			low = low | !r;
			@(posedge clk) valid <= 1'b1;
			word <= 28'h1000 + i;
			if (i > 0 && r)
				acc++;
		end
		@(posedge clk) valid <= 1'b0;
		check("fifo refuses", low, 1'b1);
		check("fifo depth", (acc >= 8 && acc <= 10), 1'b1);
		for (int i = 0; i < 3000 && ready !== 1'b1; i++)
			@(posedge clk);
		check("fifo drains", ready, 1'b1);
	endtask

	task automatic t_tx_sleep();
		@(posedge clk) tx_n <= 1'b0;
		repeat (10) @(posedge link_clk);
		#1;
		check("lane oe", lane_oe, 4'h0);
		check("fclk oe", fclk_oe, 1'b0);
		repeat (40) @(posedge link_clk);
		#1;
		check("absent strobe", strobe, 1'b1);
		@(posedge clk) tx_n <= 1'b1;
		wait_lock();
	endtask

	task automatic t_float();
		logic h;
		@(posedge clk) cut <= 1'b1;
		wait_word(28'hfffffff, h);
		check("failsafe word", h, 1'b1);
		@(posedge clk) cut <= 1'b0;
	endtask

	task automatic t_rx_sleep();
		int n;
		@(posedge clk) rx_n <= 1'b0;
		n = 0;
		while ({sink, strobe, locked} !== 30'h0 && n < `RX_SLEEP_ENTRY_CYC)
		begin
			@(posedge clk);
			n++;
		end
		check("sleep entry", n < `RX_SLEEP_ENTRY_CYC, 1'b1);
		repeat (100) @(posedge clk);
		check("sleep word", sink, 28'h0);
		@(posedge clk) rx_n <= 1'b1;
		wait_lock();
	endtask

	// ==========================================================
	// Main sequence and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		t_reset();
		t_period();
		t_word(28'h8d3c5a1);
		t_word(28'h0000001);
		t_fill();
		t_float();
		t_tx_sleep();
		t_rx_sleep();
		t_word(28'h7fffffe);
		conclude();
	end
endmodule
